// [hmb_host_port.v]
// Purpose: Pin-level front end of the host mailbox port.
// Assumes: All host pins are synchronous to ref_clk_in; mode pins are static.
// Notes:   Data pins are split into input, output and per-bit enable.
//          Outside overwrite mode the acknowledge comes in the strobe's first cycle, but read data
//          is registered and stands from the cycle after; a host that takes
//          data on the acknowledge edge must stretch its strobe by a cycle.
//          A strobe dropped during the overwrite wait ends the access
//          unanswered; a write taken before that has already landed.
//          Mode pins must not change while a host access is in progress.
//          Mailbox words are not cleared by reset, so a host can leave data
//          for the core across a reset.
`timescale 1ns/100ps
`include "hmb_consts.vh"

module hmb_host_port (
  // Clock and reset
  input  wire                     ref_clk_in,
  input  wire                     rst_in,
  // Static mode pins
  input  wire                     host_size_8bit_in,
  input  wire                     strobe_style_sel_in,
  input  wire                     addr_mux_sel_in,
  input  wire                     boot_source_sel_in,
  input  wire                     overwrite_mode_in,
  // Host control pins
  input  wire                     host_sel_n_in,
  input  wire                     host_rd_wr_sel_in,
  input  wire                     host_write_strobe_n_in,
  input  wire                     host_addr_bit2_in,
  input  wire [1:0]               host_addr_low_bits_in,
  output wire                     host_ack_n_out,
  // Host data pins
  input  wire [`HMB_DATA_W-1:0]   host_addr_data_bus_in,
  output wire [`HMB_DATA_W-1:0]   host_data_bus_out,
  output wire [`HMB_DATA_W-1:0]   host_data_bus_oe_out,
  // Core side
  input  wire                     core_we_in,
  input  wire [`HMB_ADDR_W-1:0]   core_addr_in,
  input  wire [`HMB_DATA_W-1:0]   core_wdata_in,
  output wire [`HMB_DATA_W-1:0]   core_rdata_out,
  // Status to core
  output wire                     boot_from_host_out,
  output wire                     host_wr_event_out,
  output wire                     host_rd_event_out
);

  // Access states
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_ACK  = 2'h2;
  localparam ST_HOLD = 2'h3;

  // Access state and captured attributes
  reg  [1:0]             state_q;
  reg  [1:0]             state_d;
  reg                    is_read_q;
  reg                    is_read_d;
  reg  [`HMB_ADDR_W-1:0] mux_addr_q;
  reg  [`HMB_ADDR_W-1:0] acc_addr_q;
  reg  [`HMB_ADDR_W-1:0] acc_addr_d;

  // Data, timing and status registers
  reg  [`HMB_DATA_W-1:0] rd_data_q;
  reg  [1:0]             wait_cnt_q;
  reg                    boot_from_host_q;
  reg                    boot_taken_q;
  reg                    wr_event_q;
  reg                    rd_event_q;

  // Decoded requests and access control
  wire                   rd_req;
  wire                   wr_req;
  wire                   any_req;
  wire                   take;
  wire                   host_we;
  wire                   rd_take;
  wire                   addr_latch_en;
  wire                   ack_now;
  wire                   ack_late;

  // Address, data and pin drive
  wire [`HMB_ADDR_W-1:0] live_addr;
  wire [`HMB_ADDR_W-1:0] eff_addr;
  wire [`HMB_DATA_W-1:0] host_rdata;
  wire [`HMB_DATA_W-1:0] host_rdata_sized;
  wire [`HMB_DATA_W-1:0] host_wdata;
  wire                   rd_active;
  wire                   drive_low;
  wire                   drive_high;

  // Strobe and select decode
  hmb_strobe_decode u_decode (
    .strobe_style_sel_in    (strobe_style_sel_in),
    .host_sel_n_in          (host_sel_n_in),
    .host_rd_wr_sel_in      (host_rd_wr_sel_in),
    .host_write_strobe_n_in (host_write_strobe_n_in),
    .rd_req_out             (rd_req),
    .wr_req_out             (wr_req)
  );

  // No host request counts while reset is held
  assign any_req = (rd_req | wr_req) & ~rst_in;

  // Top address pin doubles as latch enable in multiplexed mode only
  assign addr_latch_en = addr_mux_sel_in & host_addr_bit2_in;

  // Address register: loads on every clock while enable is high, held once it drops
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      mux_addr_q <= `HMB_ZERO_ADDR;
    end else if (addr_latch_en) begin
      mux_addr_q <= host_addr_data_bus_in[`HMB_ADDR_MSB:`HMB_ADDR_LSB];
    end
  end

  // Address source per protocol
  assign live_addr = addr_mux_sel_in ? mux_addr_q :
                     {host_addr_bit2_in, host_addr_low_bits_in};

  // An access is taken on the first cycle its strobe is seen in idle
  assign take     = (state_q == ST_IDLE) && any_req;
  assign eff_addr = take ? live_addr : acc_addr_q;

  // Access state machine
  always @* begin
    state_d    = state_q;
    is_read_d  = is_read_q;
    acc_addr_d = acc_addr_q;
    case (state_q)
      ST_IDLE: begin
        if (any_req) begin
          is_read_d  = rd_req;
          acc_addr_d = live_addr;
          state_d    = overwrite_mode_in ? ST_WAIT : ST_ACK;
        end
      end
      ST_WAIT: begin
        if (!any_req) begin
          state_d = ST_IDLE;
        end else if (wait_cnt_q == `HMB_OVW_DELAY_CYC) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        if (!any_req) begin
          state_d = ST_IDLE;                                   // Host ended the cycle
        end else begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!any_req) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Access state register
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Access attributes, held for the whole length of the access
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      is_read_q  <= 1'b0;
      acc_addr_q <= `HMB_ZERO_ADDR;
    end else begin
      is_read_q  <= is_read_d;
      acc_addr_q <= acc_addr_d;
    end
  end

  // Overwrite wait counter; counts only while waiting, so it never wraps
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      wait_cnt_q <= 2'h0;
    end else if (state_q == ST_WAIT) begin
      wait_cnt_q <= wait_cnt_q + 2'h1;
    end else begin
      wait_cnt_q <= 2'h0;
    end
  end

  // One read or write per access, taken in the first cycle of its strobe
  assign host_we = take && wr_req;
  assign rd_take = take && rd_req;

  // 8-bit host writes fill the upper byte with zeros
  assign host_wdata = host_size_8bit_in ?
                      {`HMB_ZERO_BYTE, host_addr_data_bus_in[`HMB_LOW_BYTE_MSB:0]} :
                      host_addr_data_bus_in;

  // Mailbox storage
  hmb_mailbox_regs u_regs (
    .ref_clk_in     (ref_clk_in),
    .rst_in         (rst_in),
    .host_we_in     (host_we),
    .host_addr_in   (eff_addr),
    .host_wdata_in  (host_wdata),
    .host_rdata_out (host_rdata),
    .core_we_in     (core_we_in & ~rst_in),
    .core_addr_in   (core_addr_in),
    .core_wdata_in  (core_wdata_in),
    .core_rdata_out (core_rdata_out)
  );

  // An 8-bit host only ever sees the low byte of a word
  assign host_rdata_sized = host_size_8bit_in ?
                            {`HMB_ZERO_BYTE, host_rdata[`HMB_LOW_BYTE_MSB:0]} :
                            host_rdata;

  // Read data register follows the addressed word every cycle
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      rd_data_q <= `HMB_ZERO_WORD;
    end else begin
      rd_data_q <= host_rdata_sized;
    end
  end

  // Pin drive only while a read is in progress, upper byte kept off in 8-bit mode
  assign rd_active  = rd_req & ((state_q == ST_IDLE) || is_read_q);
  assign drive_low  = ~rst_in & rd_active;
  assign drive_high = drive_low & ~host_size_8bit_in;

  // Per-bit pin drivers: data straight from the register, enable per byte
  genvar b;
  generate
    for (b = 0; b < `HMB_DATA_W; b = b + 1) begin : g_oe
      assign host_data_bus_out[b] = rd_data_q[b];
      if (b < `HMB_HIGH_BYTE_LSB) begin : g_lo
        assign host_data_bus_oe_out[b] = drive_low;
      end else begin : g_hi
        assign host_data_bus_oe_out[b] = drive_high;
      end
    end
  endgenerate

  // Immediate answer outside overwrite mode, late one otherwise; held in both modes while the strobe stays
  assign ack_now  = take && !overwrite_mode_in;
  assign ack_late = ((state_q == ST_ACK) || (state_q == ST_HOLD)) && any_req;

  // Acknowledge: same cycle as the access, or after the overwrite wait
  assign host_ack_n_out = rst_in ? `HMB_ACK_IDLE : ~(ack_now || ack_late);

  // Per-access event pulses for the surrounding status logic
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_event_q <= 1'b0;
      rd_event_q <= 1'b0;
    end else begin
      wr_event_q <= host_we;
      rd_event_q <= rd_take;
    end
  end

  // Event outputs come straight from their flops
  assign host_wr_event_out = wr_event_q;
  assign host_rd_event_out = rd_event_q;

  // Boot source caught once, on the first cycle after reset release
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      boot_taken_q     <= 1'b0;
      boot_from_host_q <= 1'b0;
    end else if (!boot_taken_q) begin
      boot_taken_q     <= 1'b1;
      boot_from_host_q <= boot_source_sel_in;
    end
  end

  // Boot choice stands until the next reset
  assign boot_from_host_out = boot_from_host_q;

endmodule // hmb_host_port

// [hmb_consts.vh]
// Purpose: Shared constants of the host mailbox bus front end.
// Assumes: Included by bare name from every design file of the block.
// Notes:   Definitions only; no logic lives here.
`ifndef HMB_CONSTS_VH
`define HMB_CONSTS_VH

// Data path and address sizes
`define HMB_DATA_W          16
`define HMB_BYTE_W          8
`define HMB_ADDR_W          3
`define HMB_NUM_REGS        8

// Field positions on the shared address/data lines
`define HMB_ADDR_LSB        0
`define HMB_ADDR_MSB        2
`define HMB_LOW_BYTE_MSB    7
`define HMB_HIGH_BYTE_LSB   8

// Reset and idle values
`define HMB_ACK_IDLE        1'b1
`define HMB_ZERO_BYTE       8'h00
`define HMB_ZERO_WORD       16'h0000
`define HMB_ZERO_ADDR       3'h0

// Timing: one core cycle per access, three extra cycles in overwrite mode
`define HMB_CLK_PERIOD_NS   20
`define HMB_ACCESS_NS       20
`define HMB_ACCESS_CYCLES   (`HMB_ACCESS_NS / `HMB_CLK_PERIOD_NS)
`define HMB_OVW_DELAY_CYC   2'h1

`endif

// [hmb_strobe_decode.v]
// Purpose: Turns the two host strobe pins and select into read/write requests.
// Assumes: Pins are synchronous to ref_clk_in; strobes and select active low.
// Notes:   Purely combinational; the top module owns all state.
`timescale 1ns/100ps
`include "hmb_consts.vh"

module hmb_strobe_decode (
  // Mode
  input  wire strobe_style_sel_in,
  // Host pins
  input  wire host_sel_n_in,
  input  wire host_rd_wr_sel_in,
  input  wire host_write_strobe_n_in,
  // Decoded requests
  output reg  rd_req_out,
  output reg  wr_req_out
);

  // Strobe style decode gated by select
  always @* begin
    rd_req_out = 1'b0;
    wr_req_out = 1'b0;
    if (!host_sel_n_in) begin
      if (!strobe_style_sel_in) begin
        rd_req_out = ~host_rd_wr_sel_in;                      // Pin is read strobe, low active
        wr_req_out = ~host_write_strobe_n_in;
      end else begin
        rd_req_out = ~host_write_strobe_n_in & host_rd_wr_sel_in;
        wr_req_out = ~host_write_strobe_n_in & ~host_rd_wr_sel_in;
      end
    end
  end

endmodule // hmb_strobe_decode

// [hmb_mailbox_regs.v]
// Purpose: Eight-word mailbox shared by host and core.
// Assumes: Write enables already gated off during reset.
// Notes:   Contents survive reset; host write wins over a core write to one word.
`timescale 1ns/100ps
`include "hmb_consts.vh"

module hmb_mailbox_regs (
  // Clock and reset
  input  wire                     ref_clk_in,
  input  wire                     rst_in,
  // Host port
  input  wire                     host_we_in,
  input  wire [`HMB_ADDR_W-1:0]   host_addr_in,
  input  wire [`HMB_DATA_W-1:0]   host_wdata_in,
  output wire [`HMB_DATA_W-1:0]   host_rdata_out,
  // Core port
  input  wire                     core_we_in,
  input  wire [`HMB_ADDR_W-1:0]   core_addr_in,
  input  wire [`HMB_DATA_W-1:0]   core_wdata_in,
  output reg  [`HMB_DATA_W-1:0]   core_rdata_out
);

  reg [`HMB_DATA_W-1:0] mailbox_data_reg [0:`HMB_NUM_REGS-1];

  // Per-word write with host precedence
  genvar i;
  generate
    for (i = 0; i < `HMB_NUM_REGS; i = i + 1) begin : g_word
      localparam integer               WORD_NUM = i;
      localparam [`HMB_ADDR_W-1:0]     WORD_IDX = WORD_NUM[`HMB_ADDR_W-1:0];
      always @(posedge ref_clk_in) begin
        if (host_we_in && (host_addr_in == WORD_IDX)) begin
          mailbox_data_reg[i] <= host_wdata_in;
        end else if (core_we_in && (core_addr_in == WORD_IDX)) begin
          mailbox_data_reg[i] <= core_wdata_in;
        end
      end
    end
  endgenerate

  // Host read is combinational; the top module registers it
  assign host_rdata_out = mailbox_data_reg[host_addr_in];

  // Core read registered, never stalled by host traffic
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      core_rdata_out <= `HMB_ZERO_WORD;
    end else begin
      core_rdata_out <= mailbox_data_reg[core_addr_in];
    end
  end

endmodule // hmb_mailbox_regs

// [hmb_chk.sv]
// Purpose: Port assertions for the host mailbox front end
// Assumes: Bound to hmb_host_port; one clock domain
// Notes:   A strobe start needs one idle host cycle before it
`timescale 1ns/100ps
module hmb_chk (
  // Clock, reset and modes
  input wire        ref_clk_in,
  input wire        rst_in,
  input wire        host_size_8bit_in,
  input wire        strobe_style_sel_in,
  input wire        boot_source_sel_in,
  input wire        overwrite_mode_in,
  // Host pins
  input wire        host_sel_n_in,
  input wire        host_rd_wr_sel_in,
  input wire        host_write_strobe_n_in,
  input wire        host_ack_n_out,
  input wire [15:0] host_data_bus_oe_out,
  // Status
  input wire        boot_from_host_out,
  input wire        host_wr_event_out,
  input wire        host_rd_event_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // Decoded host requests for either strobe style
  wire sel = !host_sel_n_in;
  wire wr_now = sel && !host_write_strobe_n_in && (strobe_style_sel_in ^ host_rd_wr_sel_in);
  wire rd_now = sel && (strobe_style_sel_in ? (!host_write_strobe_n_in && host_rd_wr_sel_in)
                                           : (!host_rd_wr_sel_in && host_write_strobe_n_in));
  wire busy = wr_now || rd_now;

  a_reset_quiet: assert property (disable iff (1'b0)
    rst_in |-> host_ack_n_out && host_data_bus_oe_out == 16'h0000)
    else $error("ack or data pins active in reset");
  a_wr_ack_now: assert property (
    wr_now && !$past(busy) && !overwrite_mode_in |-> !host_ack_n_out ##1 host_wr_event_out)
    else $error("write not answered in its cycle");
  a_rd_ack_now: assert property (
    rd_now && !$past(busy) && !overwrite_mode_in |-> !host_ack_n_out &&
    host_data_bus_oe_out == (host_size_8bit_in ? 16'h00FF : 16'hFFFF) ##1 host_rd_event_out)
    else $error("read not answered in its cycle");
  a_ovw_ack_wait: assert property (
    busy && !$past(busy) && overwrite_mode_in |-> host_ack_n_out)
    else $error("overwrite access acknowledged at once");
  a_sel_gates_ack: assert property (host_sel_n_in |-> host_ack_n_out)
    else $error("ack without select");
  a_upper_off: assert property (
    host_size_8bit_in |-> host_data_bus_oe_out[15:8] == 8'h00)
    else $error("upper pins driven for byte host");
  a_oe_read_only: assert property (!rd_now |-> host_data_bus_oe_out == 16'h0000)
    else $error("data pins driven outside a read");
  a_wr_pulse_one: assert property (host_wr_event_out |=> !host_wr_event_out)
    else $error("one write counted twice");
  a_boot_take: assert property (
    $fell(rst_in) |=> boot_from_host_out == $past(boot_source_sel_in))
    else $error("boot source not taken after reset");
endmodule // hmb_chk

bind hmb_host_port hmb_chk u_chk (.ref_clk_in, .rst_in, .host_size_8bit_in,
  .strobe_style_sel_in, .boot_source_sel_in, .overwrite_mode_in, .host_sel_n_in,
  .host_rd_wr_sel_in, .host_write_strobe_n_in, .host_ack_n_out, .host_data_bus_oe_out,
  .boot_from_host_out, .host_wr_event_out, .host_rd_event_out);

// [hmb_host_model.sv]
// Purpose: Behavioural host bus master for the mailbox front end
// Assumes: Mode pins stay still around each access
// Notes:   A released bus shows the inverse of the last driven value
`timescale 1ns/100ps
module hmb_host_model (
  // Clock and modes
  input  wire        ref_clk_in,
  input  wire        style_in,
  input  wire        mux_in,
  // Device answer
  input  wire        ack_n_in,
  input  wire [15:0] bus_in,
  // Host drive
  output reg         sel_n_out = 1'b1,
  output reg         rw_out = 1'b1,
  output reg         ws_n_out = 1'b1,
  output reg         a2_out = 1'b0,
  output reg  [1:0]  alow_out = 2'h0,
  output reg  [15:0] drv_out = 16'h0000,
  output reg         drv_en_out = 1'b0
);
  // Address phase, strobe, bounded wait for ack, then release
  task automatic access(input logic rd, input logic sel, input logic [2:0] a,
                        input logic [15:0] wd, input logic [15:0] junk,
                        output logic [15:0] q, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge ref_clk_in);
    sel_n_out  <= !sel;
    rw_out     <= style_in ? rd : 1'b1;
    a2_out     <= mux_in ? 1'b1 : a[2];
    alow_out   <= mux_in ? junk[1:0] : a[1:0];
    drv_out    <= mux_in ? {junk[15:3], a} : wd;
    drv_en_out <= mux_in || !rd;
    @(posedge ref_clk_in);
    a2_out     <= mux_in ? 1'b0 : a[2];
    drv_out    <= wd;
    drv_en_out <= !rd;
    rw_out     <= style_in ? rd : !rd;
    ws_n_out   <= style_in ? 1'b0 : rd;
    for (n = 0; n < 6 && !ok; n++) begin
      @(posedge ref_clk_in);
      ok = !ack_n_in;
    end
    @(posedge ref_clk_in);
    q = bus_in;
    sel_n_out  <= 1'b1;
    rw_out     <= 1'b1;
    ws_n_out   <= 1'b1;
    drv_en_out <= 1'b0;
  endtask
endmodule // hmb_host_model

// [tb.sv]
// Purpose: Self-checking bench for the host mailbox front end
// Assumes: Host model drives host pins; bench drives modes and core port
// Notes:   Every word is written before it is read
`timescale 1ns/100ps
module tb;
  // Design pins and bench state
  logic        ref_clk_in, rst_in, host_size_8bit_in, strobe_style_sel_in;
  logic        addr_mux_sel_in, boot_source_sel_in, overwrite_mode_in, core_we_in;
  logic        host_sel_n_in, host_rd_wr_sel_in, host_write_strobe_n_in, host_addr_bit2_in;
  logic        host_ack_n_out, boot_from_host_out, host_wr_event_out, host_rd_event_out;
  logic [1:0]  host_addr_low_bits_in;
  logic [2:0]  core_addr_in, a;
  logic [15:0] host_addr_data_bus_in, host_data_bus_out, host_data_bus_oe_out;
  logic [15:0] core_wdata_in, core_rdata_out, drv, q;
  logic [15:0] exp_mem [8];
  logic [31:0] seed;
  logic        drv_en, ok;
  int          n_mismatch, samples_checked, m, k;

  // Shared lines: device drive wins, a released host leaves inverted data
  assign host_addr_data_bus_in = (host_data_bus_oe_out & host_data_bus_out) |
                                 (~host_data_bus_oe_out & (drv_en ? drv : ~drv));
  // Clock
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  hmb_host_port dut (.ref_clk_in, .rst_in, .host_size_8bit_in, .strobe_style_sel_in,
    .addr_mux_sel_in, .boot_source_sel_in, .overwrite_mode_in, .host_sel_n_in,
    .host_rd_wr_sel_in, .host_write_strobe_n_in, .host_addr_bit2_in, .host_addr_low_bits_in,
    .host_ack_n_out, .host_addr_data_bus_in, .host_data_bus_out, .host_data_bus_oe_out,
    .core_we_in, .core_addr_in, .core_wdata_in, .core_rdata_out, .boot_from_host_out,
    .host_wr_event_out, .host_rd_event_out);
  hmb_host_model host (.ref_clk_in, .style_in(strobe_style_sel_in), .mux_in(addr_mux_sel_in),
    .ack_n_in(host_ack_n_out), .bus_in(host_addr_data_bus_in), .sel_n_out(host_sel_n_in),
    .rw_out(host_rd_wr_sel_in), .ws_n_out(host_write_strobe_n_in), .a2_out(host_addr_bit2_in),
    .alow_out(host_addr_low_bits_in), .drv_out(drv), .drv_en_out(drv_en));

  // Xorshift source, seeded with 14
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Word held after a host write
  function automatic logic [15:0] host_word(input logic [15:0] w, input logic s8);
    return s8 ? {8'h00, w[7:0]} : w;
  endfunction
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Host access; a missing answer ends the run
  task automatic hx(input logic rd, input logic sel, input logic [2:0] ad,
                    input logic [15:0] wd);
    logic [15:0] mk;
    mk = host_size_8bit_in ? 16'h00FF : 16'hFFFF;
    host.access(rd, sel, ad, wd, 16'(rnd()), q, ok);
    check("ack", {15'h0, sel}, {15'h0, ok});
    if (sel && !ok) summarize();
    if (sel && rd) check("host word", exp_mem[ad] & mk, q & mk);
    if (sel && !rd) exp_mem[ad] = host_word(wd, host_size_8bit_in);
  endtask
  // Core read, one cycle behind the address
  task automatic core_rd(input logic [2:0] ad);
    @(posedge ref_clk_in);
    core_addr_in <= ad;
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    check("core word", exp_mem[ad], core_rdata_out);
  endtask
  task automatic core_wr(input logic [2:0] ad, input logic [15:0] wd);
    @(posedge ref_clk_in);
    core_we_in <= 1'b1;
    core_addr_in <= ad;
    core_wdata_in <= wd;
    @(posedge ref_clk_in);
    core_we_in <= 1'b0;
    exp_mem[ad] = wd;
  endtask
  task automatic do_reset(input logic boot);
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    boot_source_sel_in <= boot;
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    check("boot", {15'h0, boot}, {15'h0, boot_from_host_out});
  endtask

  // Main sequence
  initial begin
    seed = 32'h0000000E;
    n_mismatch = 0;
    samples_checked = 0;
    {rst_in, boot_source_sel_in, host_size_8bit_in, strobe_style_sel_in} = 4'h8;
    {addr_mux_sel_in, overwrite_mode_in, core_we_in} = 3'h0;
    core_addr_in = 3'h0;
    core_wdata_in = 16'h0000;
    do_reset(1'b1);
    for (k = 0; k < 8; k++) hx(1'b0, 1'b1, 3'(k), 16'(rnd()));
    for (m = 0; m < 16; m++) begin
      @(posedge ref_clk_in);
      {overwrite_mode_in, addr_mux_sel_in, strobe_style_sel_in, host_size_8bit_in} <= 4'(m);
      for (k = 0; k < 4; k++) begin
        a = 3'(rnd());
        hx(1'b0, 1'b1, a, 16'(rnd()));
        hx(1'b1, 1'b1, a, 16'h0000);
        core_rd(a);
      end
    end
    hx(1'b0, 1'b0, 3'h5, 16'hA5A5);
    core_rd(3'h5);
    core_wr(3'h2, 16'hBEEF);
    hx(1'b1, 1'b1, 3'h2, 16'h0000);
    do_reset(1'b0);
    hx(1'b1, 1'b1, 3'h2, 16'h0000);
    summarize();
  end
endmodule // tb
